// ### mux_lp_map.vh
// register map, field positions, reset values and timing counts of the line parameter / transmit scan block
// assumes: included by bare name from the design files; definitions only
//
// Functional notes
// - line parameter register takes full-word writes only; reading it returns zero
// - transmit line enable register accepts byte writes and word writes
// - low byte bit n enables transmission on line n, from bit 00
// - enabled line with empty transmit buffer stops the transmit scanner there
// - stopped scanner raises transmitter interrupt only while interrupt enable is set
// - scanner resumes on transmit data load or enable bit cleared for stopped line
// - parameter bits 00-01 select the line, bit 00 least significant
// - parameter bit 02 set addresses no line; lines 00-03 stay unchanged
// - bits 03-04 set character length for both directions, parity excluded
// - bit 05 gives one stop unit, or two (one and half with five bits)
// - bit 06 enables parity generation on transmit and checking on receive
// - bit 07 selects odd parity when parity enabled, ignored otherwise
// - bits 08-11 select baud code; 0000=50, 0001=75, 0010=110 baud
// - per-line receiver enable bit 12, cleared by bus initialise or master clear
// - transmitter ready clears on transmit data load, reappears within 1.4 us
// - enable bits read/write, cleared by initialise or clear; bits 04-07 read zero
`ifndef MUX_LP_MAP_VH
`define MUX_LP_MAP_VH

`define APB_AW 12
`define APB_DW 32

// register byte offsets
`define CSR_OFF 12'h000
`define PARAM_OFF 12'h004
`define TXEN_OFF 12'h008
`define TXDATA_OFF 12'h00C

// register index codes
`define IDX_CSR 3'h0
`define IDX_PARAM 3'h1
`define IDX_TXEN 3'h2
`define IDX_TXDATA 3'h3
`define IDX_NONE 3'h4

// control and status fields
`define CSR_MCLR_BIT 4
`define CSR_MSE_BIT 5
`define CSR_LINE_LSB 8
`define CSR_TIE_BIT 14
`define CSR_TRDY_BIT 15

// line parameter fields
`define PARAM_LINE_LSB 0
`define PARAM_BAD_LINE_BIT 2
`define PARAM_FIELD_LSB 3
`define PARAM_FIELD_W 10
`define PARAM_STOP_BIT 2
`define PARAM_PAR_EN_BIT 3
`define PARAM_ODD_BIT 4
`define PARAM_SPEED_LSB 5
`define PARAM_RX_EN_BIT 9
`define PARAM_RESET 10'h000

// transmit line enable fields
`define TXEN_LSB 0
`define DTR_LSB 8
`define TXEN_RESET 4'h0

// data bits for length code 00
`define CHAR_LEN_BASE 4'h5

// transmitter ready reappearance bound
`define CLK_PERIOD_NS 10
`define TRDY_REAPPEAR_NS 1400
`define TRDY_REAPPEAR_CYC (`TRDY_REAPPEAR_NS / `CLK_PERIOD_NS)

`endif

// ### line_param_bank.v
// per-line parameter storage, one word per line, written through the parameter register
// assumes: wr_i is a one-cycle pulse of an accepted full-word write, clr_i a one-cycle master clear
`timescale 1ns/100ps
`default_nettype none
`include "mux_lp_map.vh"
module line_param_bank #(
  parameter N_LINES = 4,
  parameter LINE_W = 2
) (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // write side
  input wire wr_i,
  input wire clr_i,
  input wire [15:0] wdata_i,
  // per-line settings
  output wire [2*N_LINES-1:0] char_len_o,
  output wire [4*N_LINES-1:0] data_bits_o,
  output wire [N_LINES-1:0] stop2_o,
  output wire [N_LINES-1:0] stop_half_o,
  output wire [N_LINES-1:0] parity_en_o,
  output wire [N_LINES-1:0] odd_o,
  output wire [4*N_LINES-1:0] speed_o,
  output wire [N_LINES-1:0] rx_en_o
);

  function [3:0] len_to_bits;
    input [1:0] code;
    begin
      len_to_bits = `CHAR_LEN_BASE + {2'b00, code};
    end
  endfunction

  wire [LINE_W-1:0] sel_line = wdata_i[`PARAM_LINE_LSB +: LINE_W];
  wire line_ok = ~wdata_i[`PARAM_BAD_LINE_BIT];

  genvar g;
  generate
    for (g = 0; g < N_LINES; g = g + 1)
    begin : line_g
      // one word per line, so each store has a single writer
      reg [`PARAM_FIELD_W-1:0] p_r;
      always @(posedge ref_clk_i or posedge reset_i)
      begin
        if (reset_i)
          p_r <= `PARAM_RESET;
        else if (clr_i)
          p_r <= `PARAM_RESET;
        else if (wr_i && line_ok && {{(32-LINE_W){1'b0}}, sel_line} == g)
          p_r <= wdata_i[`PARAM_FIELD_LSB +: `PARAM_FIELD_W];
      end
      // shared by transmit and receive sides of the line
      assign char_len_o[2*g +: 2] = p_r[1:0];
      assign data_bits_o[4*g +: 4] = len_to_bits(p_r[1:0]);
      assign stop2_o[g] = p_r[`PARAM_STOP_BIT] & (p_r[1:0] != 2'b00);
      assign stop_half_o[g] = p_r[`PARAM_STOP_BIT] & (p_r[1:0] == 2'b00);
      assign parity_en_o[g] = p_r[`PARAM_PAR_EN_BIT];
      // odd bit means nothing without parity
      assign odd_o[g] = p_r[`PARAM_ODD_BIT] & p_r[`PARAM_PAR_EN_BIT];
      assign speed_o[4*g +: 4] = p_r[`PARAM_SPEED_LSB +: 4];
      assign rx_en_o[g] = p_r[`PARAM_RX_EN_BIT];
    end
  endgenerate

endmodule
`default_nettype wire

// ### tx_line_scanner.v
// transmitter scanner: walks the lines one per clock and parks on a line needing a character
// assumes: empty_i comes from uart logic on the same clock; load_i is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module tx_line_scanner #(
  parameter N_LINES = 4,
  parameter LINE_W = 2
) (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // control
  input wire run_i,
  input wire clr_i,
  input wire load_i,
  input wire [N_LINES-1:0] enable_i,
  input wire [N_LINES-1:0] empty_i,
  // status
  output wire ready_o,
  output wire [LINE_W-1:0] line_o
);

  localparam [LINE_W-1:0] ONE = {{(LINE_W-1){1'b0}}, 1'b1};

  reg ready_r;
  reg [LINE_W-1:0] ptr_r;

  // a full lap takes N_LINES cycles, far inside the reappearance bound
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ready_r <= 1'b0;
      ptr_r <= {LINE_W{1'b0}};
    end
    else if (clr_i)
    begin
      ready_r <= 1'b0;
      ptr_r <= {LINE_W{1'b0}};
    end
    else if (!run_i)
      ready_r <= 1'b0;
    else if (ready_r)
    begin
      // step past the served line so a stale empty flag cannot re-stop here
      if (load_i || !enable_i[ptr_r])
      begin
        ready_r <= 1'b0;
        ptr_r <= ptr_r + ONE;
      end
    end
    else if (enable_i[ptr_r] && empty_i[ptr_r])
      ready_r <= 1'b1;
    else
      ptr_r <= ptr_r + ONE;
  end

  assign ready_o = ready_r;
  assign line_o = ptr_r;

endmodule
`default_nettype wire

// ### mux_line_ctrl.v
// top of the line parameter and transmit scan block, with its apb register slave
// assumes: apb4 master on ref_clk_i; uart buffer-empty flags and load strobes on the same clock
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mux_lp_map.vh"
module mux_line_ctrl #(
  parameter N_LINES = 4,
  parameter LINE_W = 2
) (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`APB_AW-1:0] paddr_i,
  input wire [`APB_DW-1:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [`APB_DW-1:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // uart transmit side
  input wire [N_LINES-1:0] tx_buf_empty_i,
  output wire [N_LINES-1:0] tx_load_o,
  output wire [7:0] tx_char_o,
  output wire tx_irq_o,
  // per-line settings
  output wire [2*N_LINES-1:0] char_len_o,
  output wire [4*N_LINES-1:0] data_bits_o,
  output wire [N_LINES-1:0] stop2_o,
  output wire [N_LINES-1:0] stop_half_o,
  output wire [N_LINES-1:0] parity_en_o,
  output wire [N_LINES-1:0] odd_o,
  output wire [4*N_LINES-1:0] speed_o,
  output wire [N_LINES-1:0] rx_en_o,
  // modem control
  output wire [N_LINES-1:0] dtr_o
);

  // register state
  reg mse_r;
  reg tie_r;
  reg mclr_r;
  reg [N_LINES-1:0] txen_r;
  reg [N_LINES-1:0] dtr_r;
  reg [7:0] tx_char_r;
  reg [N_LINES-1:0] tx_load_r;
  reg irq_r;
  reg [`APB_DW-1:0] prdata_r;
  reg pslverr_r;
  reg [`APB_DW-1:0] rd_word;

  wire scan_ready;
  wire [LINE_W-1:0] scan_line;

  // register decode, shared by the read and write paths
  function [2:0] reg_index;
    input [`APB_AW-1:0] addr;
    begin
      case (addr)
        `CSR_OFF: reg_index = `IDX_CSR;
        `PARAM_OFF: reg_index = `IDX_PARAM;
        `TXEN_OFF: reg_index = `IDX_TXEN;
        `TXDATA_OFF: reg_index = `IDX_TXDATA;
        default: reg_index = `IDX_NONE;
      endcase
    end
  endfunction

  wire [2:0] idx = reg_index(paddr_i);
  wire setup = psel_i & ~penable_i;
  wire wr = psel_i & penable_i & pwrite_i;
  wire wr_csr = wr & (idx == `IDX_CSR);
  // only a full 16-bit word reaches the parameter store
  wire wr_param = wr & (idx == `IDX_PARAM) & (&pstrb_i[1:0]);
  wire wr_txen_lo = wr & (idx == `IDX_TXEN) & pstrb_i[0];
  wire wr_txen_hi = wr & (idx == `IDX_TXEN) & pstrb_i[1];
  wire wr_txdata_lo = wr & (idx == `IDX_TXDATA) & pstrb_i[0];
  // a character written while the scanner is not parked goes to no line
  wire tx_load_now = wr_txdata_lo & scan_ready;

  // control and status register
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mse_r <= 1'b0;
      tie_r <= 1'b0;
      mclr_r <= 1'b0;
    end
    else
    begin
      mclr_r <= wr_csr & pstrb_i[0] & pwdata_i[`CSR_MCLR_BIT];
      if (mclr_r)
      begin
        mse_r <= 1'b0;
        tie_r <= 1'b0;
      end
      else
      begin
        if (wr_csr && pstrb_i[0])
          mse_r <= pwdata_i[`CSR_MSE_BIT];
        if (wr_csr && pstrb_i[1])
          tie_r <= pwdata_i[`CSR_TIE_BIT];
      end
    end
  end

  // transmit line enables in the low byte, terminal-ready in the high byte
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      txen_r <= `TXEN_RESET;
      dtr_r <= `TXEN_RESET;
    end
    else
    begin
      if (mclr_r)
        txen_r <= `TXEN_RESET;
      else if (wr_txen_lo)
        txen_r <= pwdata_i[`TXEN_LSB +: N_LINES];
      // terminal-ready survives master clear, only bus initialise drops it
      if (wr_txen_hi)
        dtr_r <= pwdata_i[`DTR_LSB +: N_LINES];
    end
  end

  // transmit data path
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_char_r <= 8'h00;
      tx_load_r <= {N_LINES{1'b0}};
      irq_r <= 1'b0;
    end
    else
    begin
      if (wr_txdata_lo)
        tx_char_r <= pwdata_i[7:0];
      tx_load_r <= tx_load_now ? ({{(N_LINES-1){1'b0}}, 1'b1} << scan_line) : {N_LINES{1'b0}};
      irq_r <= scan_ready & tie_r;
    end
  end

  // read word assembly; the parameter register has nothing to show
  always @*
  begin
    rd_word = {`APB_DW{1'b0}};
    case (idx)
      `IDX_CSR:
      begin
        rd_word[`CSR_MSE_BIT] = mse_r;
        rd_word[`CSR_LINE_LSB +: LINE_W] = scan_line;
        rd_word[`CSR_TIE_BIT] = tie_r;
        rd_word[`CSR_TRDY_BIT] = scan_ready;
      end
      `IDX_PARAM: rd_word = {`APB_DW{1'b0}};
      `IDX_TXEN:
      begin
        // bits 04-07 and 12-15 stay zero
        rd_word[`TXEN_LSB +: N_LINES] = txen_r;
        rd_word[`DTR_LSB +: N_LINES] = dtr_r;
      end
      `IDX_TXDATA: rd_word = {`APB_DW{1'b0}};
      default: rd_word = {`APB_DW{1'b0}};
    endcase
  end

  // read data and error captured in the setup cycle so they leave flip-flops
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= pwrite_i ? 32'h0000_0000 : rd_word;
      pslverr_r <= (idx == `IDX_NONE);
    end
  end

  line_param_bank #(
    .N_LINES(N_LINES),
    .LINE_W(LINE_W)
  ) u_params (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .wr_i(wr_param),
    .clr_i(mclr_r),
    .wdata_i(pwdata_i[15:0]),
    .char_len_o(char_len_o),
    .data_bits_o(data_bits_o),
    .stop2_o(stop2_o),
    .stop_half_o(stop_half_o),
    .parity_en_o(parity_en_o),
    .odd_o(odd_o),
    .speed_o(speed_o),
    .rx_en_o(rx_en_o)
  );

  // clearing a parked line's enable releases the scanner; clearing another line's enable makes the scan skip that line
  tx_line_scanner #(
    .N_LINES(N_LINES),
    .LINE_W(LINE_W)
  ) u_scan (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .run_i(mse_r),
    .clr_i(mclr_r),
    .load_i(tx_load_now),
    .enable_i(txen_r),
    .empty_i(tx_buf_empty_i),
    .ready_o(scan_ready),
    .line_o(scan_line)
  );

  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_r;
  assign tx_load_o = tx_load_r;
  assign tx_char_o = tx_char_r;
  assign tx_irq_o = irq_r;
  assign dtr_o = dtr_r;

endmodule
`default_nettype wire

// ### mux_line_ctrl_chk.sv
// port assertions of the line parameter and transmit scan block
// assumes: bound to mux_line_ctrl, one clock domain
`timescale 1ns/100ps
`default_nettype none
module mux_line_chk #(
  parameter N_LINES = 4,
  parameter LINE_W = 2
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire [N_LINES-1:0] tx_buf_empty_i,
  input wire [N_LINES-1:0] tx_load_o,
  input wire [7:0] tx_char_o,
  input wire [2*N_LINES-1:0] char_len_o,
  input wire [4*N_LINES-1:0] data_bits_o,
  input wire [N_LINES-1:0] stop2_o,
  input wire [N_LINES-1:0] stop_half_o,
  input wire [N_LINES-1:0] parity_en_o,
  input wire [N_LINES-1:0] odd_o,
  input wire [4*N_LINES-1:0] speed_o,
  input wire [N_LINES-1:0] rx_en_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire [15*N_LINES-1:0] cfg = {char_len_o, data_bits_o, stop2_o, stop_half_o, parity_en_o, odd_o, speed_o, rx_en_o};
  // last bus word and data-load access, kept for one cycle
  logic [12:0] w_r;
  logic txdata_r;
  always @(posedge ref_clk_i)
  begin
    w_r <= pwdata_i[12:0];
    txdata_r <= psel_i && penable_i && pwrite_i && paddr_i == 12'h00c && pstrb_i[0];
  end
  wire [1:0] ln = w_r[1:0];
  sequence s_acc;
    psel_i && penable_i && pready_o;
  endsequence
  sequence s_param;
    s_acc ##0 (paddr_i == 12'h004);
  endsequence
  sequence s_param_wr;
    s_param ##0 (pwrite_i && pstrb_i[1:0] == 2'b11);
  endsequence
  property p_param_rd;
    s_param ##0 !pwrite_i |-> prdata_o == 32'h0000_0000;
  endproperty
  property p_param_strb;
    s_param ##0 (pwrite_i && pstrb_i[1:0] != 2'b11) |=> $stable(cfg);
  endproperty
  property p_bad_line;
    s_param_wr ##0 pwdata_i[2] |=> $stable(cfg);
  endproperty
  property p_cfg;
    s_param_wr ##0 !pwdata_i[2] |=> speed_o[4*ln +: 4] == w_r[11:8] && rx_en_o[ln] == w_r[12]
      && char_len_o[2*ln +: 2] == w_r[4:3] && data_bits_o[4*ln +: 4] == w_r[4:3] + 4'h5;
  endproperty
  property p_stop;
    s_param_wr ##0 !pwdata_i[2] |=> stop2_o[ln] == (w_r[5] && w_r[4:3] != 2'b00)
      && stop_half_o[ln] == (w_r[5] && w_r[4:3] == 2'b00) && parity_en_o[ln] == w_r[6];
  endproperty
  property p_odd;
    (odd_o & ~parity_en_o) == 4'h0;
  endproperty
  property p_load;
    |tx_load_o |-> $onehot(tx_load_o) && txdata_r && tx_char_o == w_r[7:0];
  endproperty
  property p_load_empty;
    |tx_load_o |-> |(tx_load_o & $past(tx_buf_empty_i));
  endproperty
  property p_txen_rd;
    s_acc ##0 (!pwrite_i && paddr_i == 12'h008) |-> prdata_o[7:4] == 4'h0 && prdata_o[31:12] == 20'h0_0000;
  endproperty
  a_param_rd: assert property (p_param_rd) else $error("parameter read not zero");
  a_param_strb: assert property (p_param_strb) else $error("partial parameter write took effect");
  a_bad_line: assert property (p_bad_line) else $error("write to absent line changed settings");
  a_cfg: assert property (p_cfg) else $error("line settings differ from written word");
  a_stop: assert property (p_stop) else $error("stop or parity setting wrong");
  a_odd: assert property (p_odd) else $error("odd parity without parity enable");
  a_load: assert property (p_load) else $error("load strobe without data write");
  a_load_empty: assert property (p_load_empty) else $error("load to a busy line");
  a_txen_rd: assert property (p_txen_rd) else $error("unused enable bits not zero");
endmodule
bind mux_line_ctrl mux_line_chk #(.N_LINES(N_LINES), .LINE_W(LINE_W)) chk (.*);
`default_nettype wire

// ### uart_tx_model.sv
// transmit buffers of the four serial lines beside the block
// assumes: load strobes one clock wide; a loaded buffer drains after hold cycles
`timescale 1ns/100ps
`default_nettype none
module uart_tx_model #(
  parameter HOLD = 12
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] tx_load_i,
  output logic [3:0] tx_buf_empty_o
);
  int busy [4];
  always @(posedge ref_clk_i or posedge reset_i)
    for (int i = 0; i < 4; i++)
      if (reset_i)
        busy[i] <= 0;
      else if (tx_load_i[i])
        busy[i] <= HOLD;
      else if (busy[i] > 0)
        busy[i] <= busy[i] - 1;
  always_comb
    for (int i = 0; i < 4; i++)
      tx_buf_empty_o[i] = busy[i] == 0;
endmodule
`default_nettype wire

// ### mux_line_params_tx_scan_ctrl_test.sv
// self-checking bench: apb master, buffer model, queued expectations
// assumes: design files and checker compiled before it
`timescale 1ns/100ps
`default_nettype none
module mux_line_params_tx_scan_ctrl_test;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] strb = 4'h0;
  logic [15:0] rnd = 16'hb7fd;
  logic [12:0] w;
  logic [12:0] lw [4];
  wire [31:0] rd;
  wire rdy, err, irq;
  wire [3:0] load, empty, s2, sh, pe, od, rx, dtr;
  wire [7:0] chr, cl;
  wire [15:0] db, sp;
  int fail_count = 0, compares = 0;
  logic [32:0] rq[$];
  logic [11:0] lq[$];
  mux_line_ctrl dut (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(addr), .pwdata_i(wd), .pstrb_i(strb), .prdata_o(rd), .pready_o(rdy), .pslverr_o(err),
    .tx_buf_empty_i(empty), .tx_load_o(load), .tx_char_o(chr), .tx_irq_o(irq), .char_len_o(cl),
    .data_bits_o(db), .stop2_o(s2), .stop_half_o(sh), .parity_en_o(pe), .odd_o(od), .speed_o(sp),
    .rx_en_o(rx), .dtr_o(dtr));
  uart_tx_model far (.ref_clk_i(clk), .reset_i(rst), .tx_load_i(load), .tx_buf_empty_o(empty));
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic report_and_stop;
    check("pending", rq.size() + lq.size(), 0);
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bail;
    fail_count++;
    report_and_stop();
  endtask
  task automatic xfer(logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    psel <= 1;
    pwr <= wr;
    addr <= a;
    wd <= d;
    strb <= s;
    @(posedge clk);
    pen <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (rdy === 1'b1)
        break;
    end
    psel <= 0;
    pen <= 0;
    if (n == 50)
      bail();
    @(posedge clk);
  endtask
  task automatic rdx(logic [11:0] a, logic [32:0] exp);
    rq.push_back(exp);
    xfer(0, a, 32'h0000_0000, 4'h0);
  endtask
  // bounded by the 1.4 us reappearance figure
  task automatic wait_irq(logic v);
    int n;
    // sampled on falling edges, away from the edge that launches irq
    for (n = 0; n < 140; n++)
    begin
      @(negedge clk);
      if (irq === v)
        break;
    end
    if (irq !== v)
      bail();
    @(posedge clk);
  endtask
  always @(posedge clk)
    if (psel && pen && !pwr && rdy)
      check("read", {err, rd}, rq.pop_front());
  always @(posedge clk)
    if (load !== 4'h0)
      check("load", {load, chr}, lq.pop_front());
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rdx(12'h008, 33'h0_0000_0000);
    rdx(12'h010, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      // odd and parity-enable walk all four pairs across the lines
      w = {rnd[12], 4'(i), rnd[7] ^ i[1], rnd[6] ^ i[0], rnd[5], 2'(i), 1'b0, 2'(i)};
      lw[i] = w;
      xfer(1, 12'h004, {19'h0_0000, w}, 4'hf);
      rdx(12'h004, 33'h0_0000_0000);
      check("len", db[4*i +: 4], 4'(w[4:3]) + 4'h5);
      check("stop", {s2[i], sh[i]}, {w[5] && w[4:3] != 0, w[5] && w[4:3] == 0});
      check("parity", {pe[i], od[i]}, {w[6], w[6] & w[7]});
      check("speed", {rx[i], sp[4*i +: 4]}, {w[12], w[11:8]});
    end
    xfer(1, 12'h004, 32'h0000_1ffc, 4'hf);
    xfer(1, 12'h004, 32'h0000_0f00, 4'h1);
    for (int i = 0; i < 4; i++)
      check("kept", {cl[2*i +: 2], sp[4*i +: 4]}, {lw[i][4:3], lw[i][11:8]});
    xfer(1, 12'h008, 32'h0000_0aff, 4'h3);
    rdx(12'h008, 33'h0_0000_0a0f);
    xfer(1, 12'h008, 32'h0000_0500, 4'h2);
    xfer(1, 12'h008, 32'h0000_000a, 4'h1);
    rdx(12'h008, 33'h0_0000_050a);
    xfer(1, 12'h000, 32'h0000_4020, 4'h3);
    wait_irq(1);
    rdx(12'h000, 33'h0_0000_c120);
    lq.push_back(12'h241);
    xfer(1, 12'h00c, 32'h0000_0041, 4'h1);
    wait_irq(0);
    wait_irq(1);
    rdx(12'h000, 33'h0_0000_c320);
    // parked on line 3, so clearing its enable releases the scanner
    xfer(1, 12'h008, 32'h0000_0002, 4'h1);
    wait_irq(0);
    wait_irq(1);
    rdx(12'h000, 33'h0_0000_c120);
    xfer(1, 12'h000, 32'h0000_0020, 4'h3);
    repeat (3) @(posedge clk);
    check("irq", irq, 1'b0);
    xfer(1, 12'h000, 32'h0000_0010, 4'h1);
    repeat (2) @(posedge clk);
    check("cleared", {cl, sp}, 24'h00_0000);
    check("cleared rx", {rx, pe, dtr}, 12'h005);
    rdx(12'h008, 33'h0_0000_0500);
    rdx(12'h000, 33'h0_0000_0000);
    // not parked: the byte is kept but no line may be loaded
    xfer(1, 12'h00c, 32'h0000_0055, 4'h1);
    check("char", chr, 8'h55);
    @(posedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
